// >>> hdl/oscfs_defines.svh
`ifndef OSCFS_DEFINES_SVH
`define OSCFS_DEFINES_SVH

`define OSCFS_ADDR_CTRL 2'h0
`define OSCFS_ADDR_DIV 2'h1
`define OSCFS_ADDR_STAT 2'h2

`define OSCFS_KEY_FIRST 8'hE7
`define OSCFS_KEY_SECOND 8'h18

`define OSCFS_BIT_INTEN 7
`define OSCFS_BIT_XTLEN 6
`define OSCFS_BIT_WDTEN 5
`define OSCFS_BIT_PRIMARY_FAIL_DETECT_EN 4
`define OSCFS_BIT_WATCHDOG_OSC_FAIL_DETECT_EN 3
`define OSCFS_BIT_FLASH_LOW_POWER_EN 2
`define OSCFS_SEL_HI 1
`define OSCFS_SEL_LO 0

`define OSCFS_SEL_INT 2'h0
`define OSCFS_SEL_XTAL 2'h1
`define OSCFS_SEL_RSVD 2'h2
`define OSCFS_SEL_WDT 2'h3

`define OSCFS_CTRL_RESET 8'hA0
`define OSCFS_DIV_RESET 8'h00
`define OSCFS_DIV_LOW_POWER 8'h08

`define OSCFS_STAT_PFAIL 0
`define OSCFS_STAT_WFAIL 1

`define OSCFS_GATE_INT 3'h1
`define OSCFS_GATE_XTAL 3'h2
`define OSCFS_GATE_WDT 3'h4
`define OSCFS_GATE_NONE 3'h0

`define OSCFS_WDT_OSC_HZ 10000
`define OSCFS_PFAIL_HZ 1000
`define OSCFS_PFAIL_TICKS (`OSCFS_WDT_OSC_HZ / `OSCFS_PFAIL_HZ)
`define OSCFS_WFAIL_CYCLES 8000
`define OSCFS_SWITCH_GAP 4

`endif

// >>> hdl/oscfs_pkg.sv
package oscfs_pkg;

    typedef enum logic [1:0] {
        OSCFS_LOCKED,
        OSCFS_KEY_SEEN,
        OSCFS_OPEN
    } oscfs_lock_t;

    typedef enum logic [1:0] {
        OSCFS_RUN,
        OSCFS_DRAIN,
        OSCFS_APPLY
    } oscfs_switch_t;

endpackage : oscfs_pkg

// >>> hdl/oscfs_tmr_if.sv
`timescale 1ns/1ps
interface oscfs_tmr_if;
    logic arm;
    logic restart;
    logic tick;
    logic expired;
    modport ctrl (output arm, output restart, output tick, input expired);
    modport tmr (input arm, input restart, input tick, output expired);
endinterface : oscfs_tmr_if

// >>> hdl/oscfs_timeout.sv
`timescale 1ns/1ps
module oscfs_timeout #(
    parameter int LIMIT = 10,
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    oscfs_tmr_if.tmr t
);
    logic [WIDTH-1:0] count_reg;
    logic expired_reg;

    if (LIMIT < 2 || LIMIT >= (1 << WIDTH)) begin : g_bad_limit
        $error("oscfs_timeout: LIMIT does not fit WIDTH");
    end

    // counts ticks while armed; restart clears; one pulse at the limit
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !t.arm || t.restart || expired_reg) begin
            count_reg <= '0;
        end else if (t.tick) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            expired_reg <= 1'b0;
        end else begin
            expired_reg <= t.arm && !t.restart && !expired_reg && t.tick
                && (count_reg == WIDTH'(LIMIT - 1));
        end
    end

    assign t.expired = expired_reg;
endmodule : oscfs_timeout

// >>> hdl/oscfs_clock_ctrl.sv
// Behaviour
// R1: reset selects internal precision oscillator
// R2: keys E7 then 18 open one write
// R3: any other sequence leaves register unchanged
// R4: keys ordered, other accesses may interleave
// R5: low-power option zero enables flash low power
// R6: low power at reset: flag set, divide 08
// R7: primary failure with detection on raises exception
// R8: primary failure switches clock to watchdog oscillator
// R9: no switch-over when watchdog already selected
// R10: primary detector fires below about 1 kHz
// R11: software keeps primary detection off below 2 kHz
// R12: watchdog failure with detection on raises exception
// R13: watchdog failure never changes clock source
// R14: after watchdog failure, no primary detection
// R15: watchdog detector fails after 8000 sysclk cycles
// R16: software clears watchdog detection when unusable
// R17: external clock: enable, wait, then select
// R18: watchdog oscillator enabled and selected at once
// R19: primary failure clears its detection enable
// R20: watchdog failure clears its detection enable
// R21: select 00 internal, 01 crystal, 11 watchdog
// R22: divide register shares the control-address unlock
// R23: source changes pass through an all-off gap
// R24: primary detector counts watchdog ticks between sysclk edges
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "oscfs_defines.svh"
module oscfs_clock_ctrl #(
    parameter int WFAIL_CYCLES = `OSCFS_WFAIL_CYCLES,
    parameter int PFAIL_TICKS = `OSCFS_PFAIL_TICKS,
    parameter int SWITCH_GAP = `OSCFS_SWITCH_GAP
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic low_power_option_bit,
    input wire logic sysclk_edge,
    input wire logic watchdog_osc_edge,
    output logic [2:0] sysclk_gate,
    output logic int_osc_en,
    output logic xtal_osc_en,
    output logic watchdog_osc_en,
    output logic flash_low_power_en,
    output logic [7:0] clock_divide,
    output logic system_exception
);
    if (WFAIL_CYCLES < 2 || WFAIL_CYCLES > 65535 || PFAIL_TICKS < 2
        || PFAIL_TICKS > 255 || SWITCH_GAP < 1 || SWITCH_GAP > 255) begin : g_bad_param
        $error("oscfs_clock_ctrl: parameter out of range");
    end

    logic [7:0] osc_control_reg;
    logic [7:0] clock_divide_reg;
    logic [1:0] status_reg;
    logic [7:0] rdata_reg;
    logic wdt_dead_reg;
    logic exc_reg;
    logic [2:0] gate_reg;
    logic [7:0] gap_reg;
    oscfs_pkg::oscfs_lock_t lock_reg;
    oscfs_pkg::oscfs_switch_t sw_reg;

    logic wr_ctrl;
    logic wr_div;
    logic wr_stat;
    logic ctrl_commit;
    logic div_commit;
    logic primary_fail_detect_en;
    logic watchdog_osc_fail_detect_en;
    logic [1:0] sysclk_source_sel;
    logic pfail;
    logic wfail;
    logic [2:0] gate_want;

    oscfs_tmr_if pf_if();
    oscfs_tmr_if wf_if();

    assign wr_ctrl = reg_wr && (reg_addr == `OSCFS_ADDR_CTRL);
    assign wr_div = reg_wr && (reg_addr == `OSCFS_ADDR_DIV);
    assign wr_stat = reg_wr && (reg_addr == `OSCFS_ADDR_STAT);
    assign ctrl_commit = wr_ctrl && (lock_reg == oscfs_pkg::OSCFS_OPEN);
    assign div_commit = wr_div && (lock_reg == oscfs_pkg::OSCFS_OPEN);
    assign primary_fail_detect_en = osc_control_reg[`OSCFS_BIT_PRIMARY_FAIL_DETECT_EN];
    assign watchdog_osc_fail_detect_en = osc_control_reg[`OSCFS_BIT_WATCHDOG_OSC_FAIL_DETECT_EN];
    assign sysclk_source_sel = osc_control_reg[`OSCFS_SEL_HI:`OSCFS_SEL_LO];

    // primary detector: watchdog ticks counted, a sysclk edge restarts
    assign pf_if.arm = primary_fail_detect_en && !wdt_dead_reg // [R14]
        && (sysclk_source_sel != `OSCFS_SEL_WDT) // [R9]
        && (sw_reg == oscfs_pkg::OSCFS_RUN);
    assign pf_if.restart = sysclk_edge; // [R24]
    assign pf_if.tick = watchdog_osc_edge; // [R24]
    assign pfail = pf_if.expired; // [R10]

    // watchdog detector: sysclk cycles counted, a watchdog edge restarts
    assign wf_if.arm = watchdog_osc_fail_detect_en;
    assign wf_if.restart = watchdog_osc_edge;
    assign wf_if.tick = sysclk_edge; // [R15]
    assign wfail = wf_if.expired;

    oscfs_timeout #(.LIMIT(PFAIL_TICKS), .WIDTH(8)) u_primary_det (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .t(pf_if.tmr)
    );

    oscfs_timeout #(.LIMIT(WFAIL_CYCLES), .WIDTH(16)) u_watchdog_det (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .t(wf_if.tmr)
    );

    // unlock sequence; keys need not be consecutive
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            lock_reg <= oscfs_pkg::OSCFS_LOCKED;
        end else begin
            unique case (lock_reg)
                oscfs_pkg::OSCFS_LOCKED: begin
                    if (wr_ctrl && reg_wdata == `OSCFS_KEY_FIRST) begin
                        lock_reg <= oscfs_pkg::OSCFS_KEY_SEEN; // [R2]
                    end
                end
                oscfs_pkg::OSCFS_KEY_SEEN: begin
                    if (wr_ctrl && reg_wdata == `OSCFS_KEY_SECOND) begin
                        lock_reg <= oscfs_pkg::OSCFS_OPEN; // [R2] [R4]
                    end
                end
                oscfs_pkg::OSCFS_OPEN: begin
                    if (wr_ctrl || wr_div) begin
                        lock_reg <= oscfs_pkg::OSCFS_LOCKED; // [R2] [R22]
                    end
                end
            endcase
        end
    end

    // control register: software write, then hardware failure actions
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            osc_control_reg <= `OSCFS_CTRL_RESET; // [R1]
            osc_control_reg[`OSCFS_BIT_FLASH_LOW_POWER_EN] <= !low_power_option_bit; // [R5] [R6]
        end else begin
            if (ctrl_commit) begin // [R3]
                osc_control_reg[7:2] <= reg_wdata[7:2];
                if (reg_wdata[1:0] != `OSCFS_SEL_RSVD) begin
                    osc_control_reg[1:0] <= reg_wdata[1:0]; // [R21]
                end
            end
            if (pfail) begin
                osc_control_reg[`OSCFS_BIT_PRIMARY_FAIL_DETECT_EN] <= 1'b0; // [R19]
                osc_control_reg[`OSCFS_BIT_WDTEN] <= 1'b1;
                osc_control_reg[1:0] <= `OSCFS_SEL_WDT; // [R8]
            end
            if (wfail) begin
                osc_control_reg[`OSCFS_BIT_WATCHDOG_OSC_FAIL_DETECT_EN] <= 1'b0; // [R20] [R13]
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            clock_divide_reg <= low_power_option_bit ? `OSCFS_DIV_RESET
                : `OSCFS_DIV_LOW_POWER; // [R6]
        end else if (div_commit) begin
            clock_divide_reg <= reg_wdata; // [R22]
        end
    end

    // failure flags: hardware set wins over write-one-to-clear
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status_reg <= 2'h0;
        end else begin
            if (pfail) begin
                status_reg[`OSCFS_STAT_PFAIL] <= 1'b1;
            end else if (wr_stat && reg_wdata[`OSCFS_STAT_PFAIL]) begin
                status_reg[`OSCFS_STAT_PFAIL] <= 1'b0;
            end
            if (wfail) begin
                status_reg[`OSCFS_STAT_WFAIL] <= 1'b1;
            end else if (wr_stat && reg_wdata[`OSCFS_STAT_WFAIL]) begin
                status_reg[`OSCFS_STAT_WFAIL] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wdt_dead_reg <= 1'b0;
        end else if (wfail) begin
            wdt_dead_reg <= 1'b1; // [R14]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            exc_reg <= 1'b0;
        end else begin
            exc_reg <= pfail || wfail; // [R7] [R12]
        end
    end

    always_comb begin
        unique case (sysclk_source_sel)
            `OSCFS_SEL_XTAL: gate_want = `OSCFS_GATE_XTAL;
            `OSCFS_SEL_WDT: gate_want = `OSCFS_GATE_WDT;
            default: gate_want = `OSCFS_GATE_INT;
        endcase
    end

    // break-before-make source switch
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sw_reg <= oscfs_pkg::OSCFS_RUN;
            gate_reg <= `OSCFS_GATE_INT; // [R1]
            gap_reg <= 8'h00;
        end else begin
            unique case (sw_reg)
                oscfs_pkg::OSCFS_RUN: begin
                    if (gate_want != gate_reg) begin
                        gate_reg <= `OSCFS_GATE_NONE; // [R23]
                        gap_reg <= 8'(SWITCH_GAP - 1);
                        sw_reg <= oscfs_pkg::OSCFS_DRAIN;
                    end
                end
                oscfs_pkg::OSCFS_DRAIN: begin
                    if (gap_reg == 8'h00) begin
                        sw_reg <= oscfs_pkg::OSCFS_APPLY;
                    end else begin
                        gap_reg <= gap_reg - 8'h01;
                    end
                end
                oscfs_pkg::OSCFS_APPLY: begin
                    gate_reg <= gate_want; // [R23]
                    sw_reg <= oscfs_pkg::OSCFS_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OSCFS_ADDR_CTRL: rdata_reg <= osc_control_reg;
                `OSCFS_ADDR_DIV: rdata_reg <= clock_divide_reg;
                `OSCFS_ADDR_STAT: rdata_reg <= {4'h0, sysclk_source_sel, status_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_reg;
    assign sysclk_gate = gate_reg;
    assign int_osc_en = osc_control_reg[`OSCFS_BIT_INTEN];
    assign xtal_osc_en = osc_control_reg[`OSCFS_BIT_XTLEN];
    assign watchdog_osc_en = osc_control_reg[`OSCFS_BIT_WDTEN];
    assign flash_low_power_en = osc_control_reg[`OSCFS_BIT_FLASH_LOW_POWER_EN];
    assign clock_divide = clock_divide_reg;
    assign system_exception = exc_reg;

    a_reset_source: assert property (@(posedge ref_clk) // [R1]
        $rose(reset_n) |-> sysclk_source_sel == `OSCFS_SEL_INT
            && gate_reg == `OSCFS_GATE_INT)
        else $error("source after reset is not internal");
    a_lock_after_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R2]
        ctrl_commit |=> lock_reg == oscfs_pkg::OSCFS_LOCKED)
        else $error("register did not relock after a write");
    a_locked_stable: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R3]
        (lock_reg != oscfs_pkg::OSCFS_OPEN && !pfail && !wfail)
            |=> $stable(osc_control_reg) && $stable(clock_divide_reg))
        else $error("locked register changed");
    a_key_order: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R4]
        (lock_reg == oscfs_pkg::OSCFS_LOCKED && wr_ctrl
            && reg_wdata == `OSCFS_KEY_SECOND) |=> lock_reg == oscfs_pkg::OSCFS_LOCKED)
        else $error("second key accepted out of order");
    a_low_power_reset: assert property (@(posedge ref_clk) // [R6]
        (!reset_n && !low_power_option_bit) |=> flash_low_power_en
            && clock_divide_reg == `OSCFS_DIV_LOW_POWER)
        else $error("low power preset missing");
    a_pfail_exception: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R7]
        pfail |=> system_exception && !primary_fail_detect_en
            && sysclk_source_sel == `OSCFS_SEL_WDT)
        else $error("primary failure not handled");
    a_pfail_switch: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R8]
        pfail |-> ##[1:300] gate_reg == `OSCFS_GATE_WDT)
        else $error("no switch to watchdog oscillator");
    a_no_arm_wdt: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R9]
        (sysclk_source_sel == `OSCFS_SEL_WDT || wdt_dead_reg) |-> !pf_if.arm)
        else $error("primary detector armed when it must not be");
    a_wfail_source: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R13]
        (wfail && !ctrl_commit && !pfail) |=> $stable(sysclk_source_sel)
            && system_exception && !watchdog_osc_fail_detect_en)
        else $error("watchdog failure mishandled");
    a_gate_gap: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R23]
        (gate_reg != `OSCFS_GATE_NONE && $changed(gate_reg)) |->
            $past(gate_reg) == `OSCFS_GATE_NONE)
        else $error("clock gate switched without a gap");

    // detectors, flags and register shape
    a_divide_relock: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R22]
        div_commit |=> lock_reg == oscfs_pkg::OSCFS_LOCKED)
        else $error("divide register did not relock after a write");
    a_low_power_off: assert property (@(posedge ref_clk) // [R5]
        (!reset_n && low_power_option_bit) |=> !flash_low_power_en
            && clock_divide_reg == `OSCFS_DIV_RESET)
        else $error("low power preset applied with option bit set");
    a_pfail_window: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R24]
        pfail |-> $past(watchdog_osc_edge) && !$past(sysclk_edge))
        else $error("primary failure without a closing watchdog tick");
    a_pfail_flag: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R19]
        pfail |=> status_reg[`OSCFS_STAT_PFAIL] && watchdog_osc_en
            && !primary_fail_detect_en)
        else $error("primary failure flag or enables wrong");
    a_wfail_window: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R15]
        wfail |-> $past(sysclk_edge) && !$past(watchdog_osc_edge))
        else $error("watchdog failure without a closing sysclk cycle");
    a_wfail_flag: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R20]
        wfail |=> status_reg[`OSCFS_STAT_WFAIL] && !watchdog_osc_fail_detect_en)
        else $error("watchdog failure flag or enable wrong");
    a_wfail_exception: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R12]
        wfail |=> system_exception)
        else $error("watchdog failure raised no exception");
    a_dead_no_pfail: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R14]
        wdt_dead_reg |=> !pfail)
        else $error("primary failure after watchdog failure");
    a_select_legal: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R21]
        sysclk_source_sel != `OSCFS_SEL_RSVD)
        else $error("reserved source select stored");
    a_exc_cause: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R7]
        system_exception |-> $past(pfail) || $past(wfail))
        else $error("exception without a detected failure");

    c_unlock_write: cover property (@(posedge ref_clk) disable iff (!reset_n) ctrl_commit);
    c_primary_fail: cover property (@(posedge ref_clk) disable iff (!reset_n) pfail);
    c_watchdog_fail: cover property (@(posedge ref_clk) disable iff (!reset_n) wfail);
    c_switch_done: cover property (@(posedge ref_clk) disable iff (!reset_n)
        sw_reg == oscfs_pkg::OSCFS_APPLY);
    c_watchdog_gate: cover property (@(posedge ref_clk) disable iff (!reset_n)
        gate_reg == `OSCFS_GATE_WDT);
endmodule : oscfs_clock_ctrl

// >>> dv/oscfs_clock_ctrl_test.sv
`timescale 1ns/1ps
module oscfs_clock_ctrl_test;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic low_power_option_bit = 1'b1;
    logic sysclk_edge = 1'b0;
    logic watchdog_osc_edge = 1'b0;
    logic [2:0] sysclk_gate;
    logic int_osc_en;
    logic xtal_osc_en;
    logic watchdog_osc_en;
    logic flash_low_power_en;
    logic [7:0] clock_divide;
    logic system_exception;
    int n_fail = 0;
    int comparisons = 0;
    int n_exc = 0;
    int cycles = 0;
    int e0;
    logic [7:0] rv;

    always #25 ref_clk = ~ref_clk;

    oscfs_clock_ctrl #(.WFAIL_CYCLES(20), .PFAIL_TICKS(10), .SWITCH_GAP(4)) oscfs_clock_ctrl_i (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .low_power_option_bit(low_power_option_bit),
        .sysclk_edge(sysclk_edge),
        .watchdog_osc_edge(watchdog_osc_edge),
        .sysclk_gate(sysclk_gate),
        .int_osc_en(int_osc_en),
        .xtal_osc_en(xtal_osc_en),
        .watchdog_osc_en(watchdog_osc_en),
        .flash_low_power_en(flash_low_power_en),
        .clock_divide(clock_divide),
        .system_exception(system_exception)
    );

    task print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // exception pulse counter and hang guard
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (system_exception === 1'b1) n_exc = n_exc + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task do_reset(input logic opt);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        low_power_option_bit <= opt;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
    endtask : do_reset

    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rdchk(input string what, input logic [1:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
        check(what, rv, exp);
    endtask : rdchk

    task unlock();
        wr(2'h0, 8'hE7);
        wr(2'h0, 8'h18);
    endtask : unlock

    // s high pulses the system clock edge, low the watchdog edge
    task pulse(input logic s, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            if (s) sysclk_edge <= 1'b1;
            else watchdog_osc_edge <= 1'b1;
            @(posedge ref_clk);
            sysclk_edge <= 1'b0;
            watchdog_osc_edge <= 1'b0;
        end
    endtask : pulse

    task exc_delta(input logic [7:0] exp);
        repeat (4) @(posedge ref_clk);
        #1;
        check("exceptions", 8'(n_exc - e0), exp);
    endtask : exc_delta

    task wait_gate(input logic [2:0] g);
        int k;
        int gz;
        gz = 0;
        for (k = 0; k < 40 && sysclk_gate !== g; k++) begin
            @(posedge ref_clk);
            #1;
            if (sysclk_gate === 3'h0) gz++;
        end
        check("gate", {5'h00, sysclk_gate}, {5'h00, g});
        check("gap length", 8'(gz), 8'h05);
    endtask : wait_gate

    task t_reset();
        do_reset(1'b1);
        rdchk("ctrl", 2'h0, 8'hA0);
        rdchk("divide", 2'h1, 8'h00);
        check("gate", {5'h00, sysclk_gate}, 8'h01);
        check("int en", {7'h00, int_osc_en}, 8'h01);
        check("flash lp", {7'h00, flash_low_power_en}, 8'h00);
        do_reset(1'b0);
        rdchk("ctrl", 2'h0, 8'hA4);
        rdchk("divide", 2'h1, 8'h08);
        check("divide port", clock_divide, 8'h08);
        check("flash lp", {7'h00, flash_low_power_en}, 8'h01);
        $display("test reset done");
    endtask : t_reset

    task t_lock();
        do_reset(1'b1);
        wr(2'h0, 8'h55);
        rdchk("ctrl", 2'h0, 8'hA0);
        wr(2'h0, 8'h18);
        wr(2'h0, 8'h55);
        rdchk("ctrl", 2'h0, 8'hA0);
        wr(2'h0, 8'hE7);
        wr(2'h3, 8'h55);
        rdchk("unmapped", 2'h3, 8'h00);
        wr(2'h1, 8'h33);
        rdchk("divide", 2'h1, 8'h00);
        wr(2'h0, 8'h18);
        wr(2'h1, 8'h10);
        rdchk("divide", 2'h1, 8'h10);
        check("divide port", clock_divide, 8'h10);
        wr(2'h0, 8'hA4);
        rdchk("ctrl", 2'h0, 8'hA0);
        unlock();
        wr(2'h0, 8'hE1);
        wait_gate(3'h2);
        rdchk("ctrl", 2'h0, 8'hE1);
        check("xtal en", {7'h00, xtal_osc_en}, 8'h01);
        unlock();
        wr(2'h0, 8'hE2);
        rdchk("ctrl", 2'h0, 8'hE1);
        rdchk("status", 2'h2, 8'h04);
        unlock();
        wr(2'h0, 8'hA0);
        wait_gate(3'h1);
        unlock();
        wr(2'h0, 8'h23);
        wait_gate(3'h4);
        rdchk("ctrl", 2'h0, 8'h23);
        rdchk("status", 2'h2, 8'h0C);
        check("wdt en", {7'h00, watchdog_osc_en}, 8'h01);
        check("int en", {7'h00, int_osc_en}, 8'h00);
        $display("test lock done");
    endtask : t_lock

    task t_pfail();
        do_reset(1'b1);
        unlock();
        wr(2'h0, 8'hF1);
        wait_gate(3'h2);
        e0 = n_exc;
        repeat (4) begin
            pulse(1'b0, 9);
            pulse(1'b1, 1);
        end
        exc_delta(8'h00);
        pulse(1'b0, 10);
        wait_gate(3'h4);
        exc_delta(8'h01);
        rdchk("ctrl", 2'h0, 8'hE3);
        check("wdt en", {7'h00, watchdog_osc_en}, 8'h01);
        rdchk("status", 2'h2, 8'h0D);
        wr(2'h2, 8'h01);
        rdchk("status", 2'h2, 8'h0C);
        unlock();
        wr(2'h0, 8'hF3);
        e0 = n_exc;
        pulse(1'b0, 15);
        exc_delta(8'h00);
        check("gate", {5'h00, sysclk_gate}, 8'h04);
        rdchk("ctrl", 2'h0, 8'hF3);
        $display("test primary failure done");
    endtask : t_pfail

    task t_wfail();
        do_reset(1'b1);
        unlock();
        wr(2'h0, 8'hA8);
        e0 = n_exc;
        pulse(1'b1, 19);
        pulse(1'b0, 1);
        pulse(1'b1, 19);
        exc_delta(8'h00);
        pulse(1'b1, 1);
        exc_delta(8'h01);
        rdchk("ctrl", 2'h0, 8'hA0);
        rdchk("status", 2'h2, 8'h02);
        check("gate", {5'h00, sysclk_gate}, 8'h01);
        unlock();
        wr(2'h0, 8'hB0);
        e0 = n_exc;
        pulse(1'b0, 15);
        exc_delta(8'h00);
        check("gate", {5'h00, sysclk_gate}, 8'h01);
        $display("test watchdog failure done");
    endtask : t_wfail

    initial begin
        t_reset();
        t_lock();
        t_pfail();
        t_wfail();
        print_verdict();
    end
endmodule : oscfs_clock_ctrl_test
